/* bcx_exec.sv */
// Functional notes
// [RULE1] increment file, zero flag only
// [RULE2] destination bit 0 accumulator, 1 file
// [RULE3] or accumulator into file, zero flag only
// [RULE4] copy file, zero flag, one cycle
// [RULE5] store accumulator into file, no flags
// [RULE6] load literal into accumulator, no flags
// [RULE7] irq return pops stack, two cycles
// [RULE8] irq return sets global interrupt enable
// [RULE9] return with literal loads accumulator, pops
// [RULE10] subroutine return pops stack, two cycles
// [RULE11] rotate left through carry
// [RULE12] rotate right through carry
// [RULE13] sleep clears watchdog, sets expiry, clears sleep
// [RULE14] sleep halts until woken
// [RULE15] literal minus accumulator with carry flags
// [RULE16] file minus accumulator with carry flags
// [RULE17] xor literal, zero flag only
// [RULE18] nibble exchange, no flags
// [RULE19] xor file, zero flag only
// [RULE20] zero flag from result; idle op no effect
`timescale 1ns/100ps
`default_nettype none
`include "bcx_map.svh"
module bcx_exec (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hsel,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             halted
);
	////////////////////////////////////////////////////////////////////
	// bus slave
	logic        wr_pend;
	logic        rd_pend;
	logic [31:0] a_addr;
	logic [13:0] instr;
	logic [7:0]  acc;
	logic [7:0]  status;
	logic [7:0]  irq_control_reg;
	logic [7:0]  watchdog_counter;
	logic [7:0]  dog_prescale;
	logic [12:0] program_counter;
	logic [6:0]  faddr;
	logic [7:0]  fmem [0:`BCX_FILE_DEPTH-1];
	logic [12:0] stk [0:`BCX_STACK_DEPTH-1];
	logic [2:0]  sp;
	logic [3:0]  stk_cnt;
	bcx_pkg::bcx_state_e state;
	logic        go;
	logic        wake;
	logic        cfg_w;
	wire logic   acc_phase = hsel & hready & htrans[1];
	wire logic   bus_w = wr_pend;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			a_addr  <= 32'h0000_0000;
		end else begin
			wr_pend <= acc_phase & hwrite;
			rd_pend <= acc_phase & ~hwrite;
			if (acc_phase) begin
				a_addr <= haddr;
			end
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end
	wire logic [12:0] head = stk[sp - 3'd1];
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hrdata <= 32'h0000_0000;
		end else if (acc_phase & ~hwrite) begin
			unique case (haddr)
			`BCX_A_CTRL:    hrdata <= {30'h0, state == bcx_pkg::BCX_SLEEP,
				state != bcx_pkg::BCX_IDLE};
			`BCX_A_INSTR:   hrdata <= {18'h0, instr};
			`BCX_A_ACC:     hrdata <= {24'h0, acc};
			`BCX_A_STATUS:  hrdata <= {24'h0, status};
			`BCX_A_PC:      hrdata <= {19'h0, program_counter};
			`BCX_A_IRQCTL:  hrdata <= {24'h0, irq_control_reg};
			`BCX_A_WDOG:    hrdata <= {16'h0, dog_prescale,
				watchdog_counter};
			`BCX_A_FADDR:   hrdata <= {25'h0, faddr};
			`BCX_A_FDATA:   hrdata <= {24'h0, fmem[faddr]};
			`BCX_A_STKHEAD: hrdata <= {15'h0, stk_cnt, head};
			default:        hrdata <= 32'h0000_0000;
			endcase
		end
	end
	assign cfg_w = bus_w & (state == bcx_pkg::BCX_IDLE);
	assign go   = bus_w & (a_addr == `BCX_A_CTRL) & hwdata[`BCX_B_GO];
	assign wake = bus_w & (a_addr == `BCX_A_CTRL) & hwdata[`BCX_B_WAKE];
	////////////////////////////////////////////////////////////////////
	// decode
	wire logic [7:0] fval = fmem[instr[6:0]];
	wire logic       dbit = instr[7];
	wire logic [7:0] lit  = instr[7:0];
	wire logic       cin  = status[`BCX_B_C];
	function automatic logic is_op(input logic [13:0] i,
		input logic [5:0] op);
		is_op = i[13:8] == op;
	endfunction : is_op
	logic [7:0] res;
	logic       to_acc;
	logic       to_file;
	logic       upd_z;
	logic       upd_c;
	logic       upd_dc;
	logic       new_c;
	logic       new_dc;
	logic [8:0] diff;
	logic [4:0] ndiff;
	always_comb begin
		res     = 8'h00;
		to_acc  = 1'b0;
		to_file = 1'b0;
		upd_z   = 1'b0;
		upd_c   = 1'b0;
		upd_dc  = 1'b0;
		new_c   = 1'b0;
		new_dc  = 1'b0;
		diff    = 9'h000;
		ndiff   = 5'h00;
		if (is_op(instr, 6'h0a)) begin
			res = fval + 8'h01; // [RULE1]
			upd_z = 1'b1;
			to_acc = ~dbit; // [RULE2]
			to_file = dbit; // [RULE2]
		end else if (is_op(instr, 6'h04)) begin
			res = acc | fval; // [RULE3]
			upd_z = 1'b1;
			to_acc = ~dbit;
			to_file = dbit;
		end else if (is_op(instr, 6'h08)) begin
			res = fval; // [RULE4]
			upd_z = 1'b1;
			to_acc = ~dbit;
			to_file = dbit;
		end else if (is_op(instr, 6'h00) & dbit) begin
			res = acc; // [RULE5]
			to_file = 1'b1;
		end else if (instr[13:10] == 4'hc) begin
			res = lit; // [RULE6]
			to_acc = 1'b1;
		end else if (instr[13:10] == 4'hd) begin
			res = lit; // [RULE9]
			to_acc = 1'b1;
		end else if (is_op(instr, 6'h0d)) begin
			res = {fval[6:0], cin}; // [RULE11]
			new_c = fval[7];
			upd_c = 1'b1;
			to_acc = ~dbit;
			to_file = dbit;
		end else if (is_op(instr, 6'h0c)) begin
			res = {cin, fval[7:1]}; // [RULE12]
			new_c = fval[0];
			upd_c = 1'b1;
			to_acc = ~dbit;
			to_file = dbit;
		end else if (instr[13:9] == 5'h1e) begin
			diff = {1'b0, lit} - {1'b0, acc}; // [RULE15]
			ndiff = {1'b0, lit[3:0]} - {1'b0, acc[3:0]};
			res = diff[7:0];
			new_c = ~diff[8];
			new_dc = ~ndiff[4];
			upd_c = 1'b1;
			upd_dc = 1'b1;
			upd_z = 1'b1;
			to_acc = 1'b1;
		end else if (is_op(instr, 6'h02)) begin
			diff = {1'b0, fval} - {1'b0, acc}; // [RULE16]
			ndiff = {1'b0, fval[3:0]} - {1'b0, acc[3:0]};
			res = diff[7:0];
			new_c = ~diff[8];
			new_dc = ~ndiff[4];
			upd_c = 1'b1;
			upd_dc = 1'b1;
			upd_z = 1'b1;
			to_acc = ~dbit;
			to_file = dbit;
		end else if (is_op(instr, 6'h3a)) begin
			res = acc ^ lit; // [RULE17]
			upd_z = 1'b1;
			to_acc = 1'b1;
		end else if (is_op(instr, 6'h0e)) begin
			res = {fval[3:0], fval[7:4]}; // [RULE18]
			to_acc = ~dbit;
			to_file = dbit;
		end else if (is_op(instr, 6'h06)) begin
			res = acc ^ fval; // [RULE19]
			upd_z = 1'b1;
			to_acc = ~dbit;
			to_file = dbit;
		end
	end
	wire logic op_irq_return = instr == 14'h0009;
	wire logic op_return = instr == 14'h0008;
	wire logic op_return_with_literal  = instr[13:10] == 4'hd;
	wire logic op_sleep  = instr == 14'h0063;
	wire logic op_pop    = op_irq_return | op_return | op_return_with_literal;
	wire logic exec      = state == bcx_pkg::BCX_EXEC;
	////////////////////////////////////////////////////////////////////
	// sequencer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= bcx_pkg::BCX_IDLE;
		end else begin
			unique case (state)
			bcx_pkg::BCX_IDLE: if (go) begin
				state <= bcx_pkg::BCX_EXEC;
			end
			bcx_pkg::BCX_EXEC: if (op_pop) begin
				state <= bcx_pkg::BCX_SECOND; // [RULE7] [RULE10]
			end else if (op_sleep) begin
				state <= bcx_pkg::BCX_SLEEP; // [RULE14]
			end else begin
				state <= bcx_pkg::BCX_IDLE;
			end
			bcx_pkg::BCX_SECOND: state <= bcx_pkg::BCX_IDLE;
			bcx_pkg::BCX_SLEEP: if (wake) begin
				state <= bcx_pkg::BCX_IDLE; // [RULE14]
			end
			endcase
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			halted <= 1'b0;
		end else begin
			halted <= exec ? op_sleep
				: (state == bcx_pkg::BCX_SLEEP) & ~wake; // [RULE14]
		end
	end
	////////////////////////////////////////////////////////////////////
	// architectural state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			instr <= 14'h0000;
			faddr <= 7'h00;
		end else if (cfg_w) begin
			if (a_addr == `BCX_A_INSTR) begin
				instr <= hwdata[13:0];
			end
			if (a_addr == `BCX_A_FADDR) begin
				faddr <= hwdata[6:0];
			end
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			acc <= 8'h00;
		end else if (exec & to_acc) begin
			acc <= res; // [RULE2] [RULE6] [RULE9]
		end else if (cfg_w & (a_addr == `BCX_A_ACC)) begin
			acc <= hwdata[7:0];
		end
	end
	always_ff @(posedge clk) begin
		if (exec & to_file) begin
			fmem[instr[6:0]] <= res; // [RULE2] [RULE5]
		end else if (cfg_w & (a_addr == `BCX_A_FDATA)) begin
			fmem[faddr] <= hwdata[7:0];
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			status <= `BCX_STATUS_RST;
		end else if (exec) begin
			if (upd_z) begin
				status[`BCX_B_Z] <= res == 8'h00; // [RULE20]
			end
			if (upd_c) begin
				status[`BCX_B_C] <= new_c; // [RULE11] [RULE12]
			end
			if (upd_dc) begin
				status[`BCX_B_DC] <= new_dc; // [RULE15] [RULE16]
			end
			if (op_sleep) begin
				status[`BCX_B_TO] <= 1'b1; // [RULE13]
				status[`BCX_B_PD] <= 1'b0; // [RULE13]
			end
		end else if (cfg_w & (a_addr == `BCX_A_STATUS)) begin
			status <= hwdata[7:0];
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			watchdog_counter <= 8'h00;
			dog_prescale     <= 8'h00;
		end else if (exec & op_sleep) begin
			watchdog_counter <= 8'h00; // [RULE13]
			dog_prescale     <= 8'h00; // [RULE13]
		end else if (cfg_w & (a_addr == `BCX_A_WDOG)) begin
			watchdog_counter <= hwdata[7:0];
			dog_prescale     <= hwdata[15:8];
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_control_reg <= 8'h00;
		end else if (exec & op_irq_return) begin
			irq_control_reg[`BCX_B_GIE] <= 1'b1; // [RULE8]
		end else if (cfg_w & (a_addr == `BCX_A_IRQCTL)) begin
			irq_control_reg <= hwdata[7:0];
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			program_counter <= 13'h0000;
			sp              <= 3'h0;
			stk_cnt         <= 4'h0;
		end else if (exec & op_pop) begin
			program_counter <= head; // [RULE7] [RULE9] [RULE10]
			sp <= sp - 3'd1;
			stk_cnt <= (stk_cnt == 4'h0) ? 4'h0 : stk_cnt - 4'h1;
		end else if (exec & ~op_sleep) begin
			program_counter <= program_counter + 13'h0001; // [RULE20]
		end else if (cfg_w & (a_addr == `BCX_A_PC)) begin
			program_counter <= hwdata[12:0];
		end else if (cfg_w & (a_addr == `BCX_A_STKPUSH)) begin
			sp <= sp + 3'd1;
			stk_cnt <= (stk_cnt == 4'h8) ? 4'h8 : stk_cnt + 4'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (cfg_w & (a_addr == `BCX_A_STKPUSH)) begin
			stk[sp] <= hwdata[12:0];
		end
	end
endmodule : bcx_exec
`default_nettype wire

/* bcx_map.svh */
`ifndef BCX_MAP_SVH
`define BCX_MAP_SVH
`define BCX_A_CTRL      32'h0000_0000
`define BCX_A_INSTR     32'h0000_0004
`define BCX_A_ACC       32'h0000_0008
`define BCX_A_STATUS    32'h0000_000c
`define BCX_A_PC        32'h0000_0010
`define BCX_A_IRQCTL    32'h0000_0014
`define BCX_A_WDOG      32'h0000_0018
`define BCX_A_FADDR     32'h0000_001c
`define BCX_A_FDATA     32'h0000_0020
`define BCX_A_STKPUSH   32'h0000_0024
`define BCX_A_STKHEAD   32'h0000_0028
`define BCX_B_C         0
`define BCX_B_DC        1
`define BCX_B_Z         2
`define BCX_B_PD        3
`define BCX_B_TO        4
`define BCX_B_GIE       7
`define BCX_B_GO        0
`define BCX_B_WAKE      1
`define BCX_STATUS_RST  8'h18
`define BCX_STACK_DEPTH 8
`define BCX_FILE_DEPTH  128
`endif

/* bcx_pkg.sv */
package bcx_pkg;
	typedef enum logic [1:0] {
		BCX_IDLE,
		BCX_EXEC,
		BCX_SECOND,
		BCX_SLEEP
	} bcx_state_e;
	typedef logic [12:0] bcx_pc_t;
endpackage : bcx_pkg

/* bcx_exec_props.sv */
`timescale 1ns/100ps
`default_nettype none
`include "bcx_map.svh"
module bcx_exec_props (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hsel,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        halted
);
	logic [31:0] a_q;
	logic        w_q;
	logic        r_q;
	logic [13:0] ins_q;
	logic [13:0] gi;
	logic [2:0]  st;
	wire         ctl = w_q && a_q == `BCX_A_CTRL;
	wire         go = ctl && hwdata[0];
	wire         wake = ctl && hwdata[1];
	wire         rs = r_q && st == 3'd5;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////
	// data phase tracking
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			w_q <= 1'b0;
			r_q <= 1'b0;
		end else begin
			w_q <= hsel && hready && htrans[1] && hwrite;
			r_q <= hsel && hready && htrans[1] && !hwrite;
		end
	end
	always_ff @(posedge clk) begin
		if (hsel && hready && htrans[1])
			a_q <= haddr;
	end
	// last started instruction and cycles since its start
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ins_q <= 14'h0000;
			gi <= 14'h0000;
			st <= 3'd0;
		end else begin
			if (w_q && a_q == `BCX_A_INSTR)
				ins_q <= hwdata[13:0];
			if (go) begin
				gi <= ins_q;
				st <= 3'd1;
			end else if (w_q)
				st <= 3'd0;
			else if (st != 3'd0 && st != 3'd5)
				st <= st + 3'd1;
		end
	end
	////////////////////////////////////////////////////////////
	AST_SLEEP_HALTS: assert property (
		go && ins_q == 14'h0063 |-> ##[1:4] halted)
		else $error("sleep did not halt");
	AST_HALT_CAUSE: assert property (
		$rose(halted) |-> gi == 14'h0063)
		else $error("halt without sleep");
	AST_HALT_HOLDS: assert property (
		halted && !wake |=> halted)
		else $error("halt left without wake");
	AST_WAKE: assert property (
		halted && wake |-> ##[1:4] !halted)
		else $error("wake ignored");
	AST_SLEEP_FLAGS: assert property (
		r_q && a_q == `BCX_A_STATUS && halted |->
		hrdata[4:3] == 2'b10)
		else $error("sleep status flags wrong");
	AST_SLEEP_WDOG: assert property (
		r_q && a_q == `BCX_A_WDOG && halted |->
		hrdata[15:0] == 16'h0000)
		else $error("watchdog not cleared");
	AST_LIT_ACC: assert property (
		rs && a_q == `BCX_A_ACC && gi[13:11] == 3'b110 |->
		hrdata[7:0] == gi[7:0])
		else $error("literal not in accumulator");
	AST_GIE_SET: assert property (
		rs && a_q == `BCX_A_IRQCTL && gi == 14'h0009 |-> hrdata[7])
		else $error("interrupt enable not set");
	cover property (go && ins_q == 14'h0063);
	cover property (rs && gi == 14'h0009);
	cover property (halted && wake);
endmodule : bcx_exec_props
bind bcx_exec bcx_exec_props props_u (.clk(clk), .reset_n(reset_n),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hsel(hsel), .hready(hready), .hrdata(hrdata), .halted(halted));
`default_nettype wire

/* bcx_prog_rom.sv */
`timescale 1ns/100ps
`default_nettype none
module bcx_prog_rom (
	input wire logic [1:0]  idx,
	output logic     [13:0] word
);
	// literal return, subroutine return, irq return, sleep
	always_comb begin
		case (idx)
			2'd0: word = 14'h3400;
			2'd1: word = 14'h0008;
			2'd2: word = 14'h0009;
			default: word = 14'h0063;
		endcase
	end
endmodule : bcx_prog_rom
`default_nettype wire

/* byte_cpu_instruction_exec_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "bcx_map.svh"
module byte_cpu_instruction_exec_test;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        halted;
	logic [1:0]  pi = 2'd0;
	logic [13:0] word;
	logic [31:0] q;
	logic [31:0] rnd = 32'hced327b4;
	logic [13:0] ins;
	logic [11:0] m;
	logic [7:0]  w;
	logic [7:0]  f;
	logic [2:0]  s;
	int          error_cnt = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          j;
	logic [5:0]  ops [12] = '{6'h0a, 6'h04, 6'h08, 6'h06, 6'h02, 6'h0e,
		6'h0d, 6'h0c, 6'h3c, 6'h3a, 6'h00, 6'h30};
	always #25 clk = ~clk;
	bcx_exec dut_u (.clk(clk), .reset_n(reset_n), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hsel(1'b1), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .halted(halted));
	bcx_prog_rom rom_u (.idx(pi), .word(word));
	////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	// expected {to file, result, z dc c}
	function automatic logic [11:0] model(input logic [13:0] i,
		input logic [7:0] w, input logic [7:0] f, input logic [2:0] s);
		logic [7:0] a;
		logic [7:0] r;
		a = (i[13:12] == 2'b11) ? i[7:0] : f;
		case (i[13:8])
			6'h0a: r = f + 8'h01;
			6'h04: r = w | f;
			6'h08: r = f;
			6'h06, 6'h3a: r = w ^ a;
			6'h02, 6'h3c: begin
				r = a - w;
				s[1:0] = {w[3:0] <= a[3:0], w <= a};
			end
			6'h0e: r = {f[3:0], f[7:4]};
			6'h0d: {s[0], r} = {f, s[0]};
			6'h0c: {r, s[0]} = {s[0], f};
			6'h30: r = i[7:0];
			default: r = w;
		endcase
		if (i[13:8] inside {6'h0a, 6'h04, 6'h08, 6'h06, 6'h3a, 6'h02, 6'h3c})
			s[2] = r == 8'h00;
		return {i[13:12] == 2'b00 && i[7], r, s};
	endfunction : model
	task automatic bus(input logic wr, input logic [31:0] a, d);
		@(posedge clk);
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic run(input logic [13:0] i);
		logic pop;
		pop = i == 14'h0008 || i == 14'h0009 || i[13:10] == 4'hd;
		bus(1'b1, `BCX_A_INSTR, {18'h0, i});
		bus(1'b1, `BCX_A_CTRL, 32'h1);
		j = 0;
		do begin
			bus(1'b0, `BCX_A_CTRL, 32'h0);
			j++;
		end while (q[1:0] == 2'b01 && j < 20);
		chk("polls", j, pop ? 32'd2 : 32'd1);
	endtask : run
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		bus(1'b0, `BCX_A_STATUS, 32'h0);
		chk("status", q, 32'h18);
		for (int n = 0; n < 48; n++) begin
			rnd = xs(rnd);
			{s, f, w} = rnd[18:0];
			ins = {ops[n % 12], rnd[31:24]};
			if (n < 12) begin
				{f, w} = 16'hffff;
				ins[6:0] = 7'h7f;
			end
			if (ins[13:8] == 6'h00 && !ins[7])
				ins = 14'h0000;
			bus(1'b1, `BCX_A_ACC, {24'h0, w});
			bus(1'b1, `BCX_A_FADDR, {25'h0, ins[6:0]});
			bus(1'b1, `BCX_A_FDATA, {24'h0, f});
			bus(1'b1, `BCX_A_STATUS, {24'h0, 5'h03, s});
			run(ins);
			m = model(ins, w, f, s);
			bus(1'b0, `BCX_A_ACC, 32'h0);
			chk("acc", q, {24'h0, m[11] ? w : m[10:3]});
			bus(1'b0, `BCX_A_FDATA, 32'h0);
			chk("file", q, {24'h0, m[11] ? m[10:3] : f});
			bus(1'b0, `BCX_A_STATUS, 32'h0);
			chk("flags", q & 32'h7, {29'h0, m[2:0]});
		end
		$display("operation test done");
		for (int n = 0; n < 3; n++) begin
			rnd = xs(rnd);
			pi = n[1:0];
			bus(1'b1, `BCX_A_STKPUSH, {19'h0, rnd[12:0]});
			bus(1'b1, `BCX_A_IRQCTL, 32'h0);
			bus(1'b1, `BCX_A_ACC, {24'h0, rnd[31:24]});
			ins = word;
			if (n == 0)
				ins[7:0] = rnd[23:16];
			run(ins);
			bus(1'b0, `BCX_A_PC, 32'h0);
			chk("pc", q & 32'h1fff, {19'h0, rnd[12:0]});
			bus(1'b0, `BCX_A_IRQCTL, 32'h0);
			chk("gie", {31'h0, q[7]}, {31'h0, n == 2});
			bus(1'b0, `BCX_A_ACC, 32'h0);
			chk("acc", q, {24'h0, n == 0 ? rnd[23:16] : rnd[31:24]});
		end
		$display("return test done");
		pi = 2'd3;
		bus(1'b1, `BCX_A_WDOG, 32'h0000ffff);
		run(word);
		chk("halted", {31'h0, halted}, 32'h1);
		bus(1'b0, `BCX_A_STATUS, 32'h0);
		chk("sleep flags", q & 32'h18, 32'h10);
		bus(1'b0, `BCX_A_WDOG, 32'h0);
		chk("watchdog", q & 32'hffff, 32'h0);
		bus(1'b1, `BCX_A_CTRL, 32'h2);
		j = 0;
		while (halted !== 1'b0 && j < 20) begin
			@(posedge clk);
			j++;
		end
		chk("woken", {31'h0, halted}, 32'h0);
		$display("sleep test done");
		give_verdict();
	end
endmodule : byte_cpu_instruction_exec_test
`default_nettype wire
